// >>> logic/mdio_master_pkg.sv
// constants, register map and types for the management-interface master
`default_nettype none
package mdio_master_pkg;
   // core clock and management clock limits
   localparam int CLK_MHZ = 250;
   localparam int MDC_MAX_MHZ = 25;
   localparam int MDC_MIN_HALF_INT = (CLK_MHZ + 2 * MDC_MAX_MHZ - 1) / (2 * MDC_MAX_MHZ);
   localparam logic [7:0] MDC_MIN_HALF = MDC_MIN_HALF_INT[7:0];

   // register byte addresses
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_DATA = 8'h08;
   localparam logic [7:0] ADDR_CFG = 8'h0C;
   localparam logic [7:0] ADDR_SCAN_RANGE = 8'h10;
   localparam logic [7:0] ADDR_SCAN_CMP = 8'h14;
   localparam logic [7:0] ADDR_LAST_RESULT = 8'h18;
   localparam logic [7:0] ADDR_LAST_VALID = 8'h1C;
   localparam logic [7:0] ADDR_STICKY = 8'h20;

   // command register fields
   localparam int CMD_VALID_POS = 0;
   localparam int CMD_SCAN_POS = 1;
   localparam int CMD_ONEPASS_POS = 2;
   localparam int CMD_OPR_POS = 3;
   localparam int CMD_REG_POS = 5;
   localparam int CMD_PHY_POS = 10;
   localparam int CMD_WDATA_POS = 15;

   // status register fields
   localparam int STAT_ACTIVE_POS = 0;
   localparam int STAT_RDPEND_POS = 1;
   localparam int STAT_WRPEND_POS = 2;
   localparam int STAT_QFULL_POS = 3;
   localparam int STAT_SCAN_POS = 4;

   // data register: outcome bit is 1 on a failed read
   localparam int DATA_FAIL_POS = 16;

   // configuration fields and reset values
   localparam int CFG_DIV_POS = 0;
   localparam int CFG_ST_POS = 8;
   localparam logic [7:0] CFG_DIV_RST = 8'h31;
   localparam logic [1:0] ST_CLAUSE22 = 2'h1;
   localparam logic [1:0] ST_CLAUSE45 = 2'h0;

   // scan range fields (low phy, high phy) and compare fields (expect, mask)
   localparam int SCAN_LO_POS = 0;
   localparam int SCAN_HI_POS = 8;
   localparam int CMP_EXP_POS = 0;
   localparam int CMP_MASK_POS = 16;
   localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

   // frame layout
   localparam logic [6:0] FRAME_BITS = 7'h40;
   localparam logic [6:0] TA_INDEX = 7'h2E;
   localparam logic [31:0] PREAMBLE = 32'hFFFF_FFFF;
   localparam logic [1:0] TA_DRIVE = 2'h2;

   // command queue
   localparam int QUEUE_DEPTH = 2;

   typedef enum logic {ENG_IDLE, ENG_RUN} eng_state_e;
endpackage
`default_nettype wire

// >>> logic/mdio_management_master.sv
// management-interface master: registers, command queue, phy scan and mdc/mdio frame engine
// Notes on behaviour
// [R1] frames carry clause 22 or clause 45 start code and operation code
// [R2] mdio is driven and sampled at each falling edge of the generated mdc
// [R3] mdio output released between frames and from turnaround onward on reads
// [R4] mdc is core clock divided by a setting, never faster than 25 MHz
// [R5] software loads phy, register, opcode, data; writing valid 1 starts it
// [R6] the command valid flag clears itself once the command is accepted
// [R7] software writes scan enable 0 for single commands
// [R8] read pending and write pending flags show outstanding single operations
// [R9] read data and outcome bit stored after each read; data good only on success
// [R10] single commands wait in a small queue; queue full flag gates new single commands, not scans
// [R11] each completed read overwrites the single read data register
// [R12] reset selects clause 22 start code; software changes it for clause 45
// [R13] scan reads a register repeatedly and flags masked mismatches
// [R14] a scan pass visits phys from low bound to high bound
// [R15] scan starts on valid with scan enable 1 and a read opcode
// [R16] one-pass flag stops scanning after a single pass over the range
// [R17] while scanning only scan controls, opcode and register index are used
// [R18] mismatch when any masked bit differs from expected value
// [R19] latest result holds one bit per phy, 0 meaning mismatch
// [R20] latest valid holds one bit per phy, 1 meaning read succeeded
// [R21] sticky register collects mismatches; reading returns it and sets all ones
// [R22] interrupt raised on any sticky mismatch, cleared by reading sticky register
// [R23] frame: 32 ones, start, opcode, phy, register, turnaround, 16 data bits
// [R24] active flag stays set from acceptance until the last transaction ends
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
module mdio_management_master
   import mdio_master_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic mdc,
   output logic mdioOut,
   output logic mdioOe,
   input wire logic mdioIn,
   output logic irq
);
   import mdio_master_pkg::*;

   // configuration and command registers
   logic [7:0] divSetting;
   logic [1:0] startCode;
   logic [4:0] scanLo;
   logic [4:0] scanHi;
   logic [15:0] expectVal;
   logic [15:0] cmpMask;
   logic cmdValid;
   logic cmdScan;
   logic cmdOnePass;
   logic [1:0] cmdOpr;
   logic [4:0] cmdReg;
   logic [4:0] cmdPhy;
   logic [15:0] cmdWdata;

   // results
   logic [15:0] readValue;
   logic readFail;
   logic [31:0] lastResult;
   logic [31:0] lastValid;
   logic [31:0] sticky;

   // scan state
   logic scanOn;
   logic scanOnePass;
   logic [1:0] scanOpr;
   logic [4:0] scanReg;
   logic [4:0] scanPhy;

   // command queue
   logic [27:0] qMem [QUEUE_DEPTH];
   logic [QUEUE_DEPTH-1:0] qUsed;
   logic qWrPtr;
   logic qRdPtr;
   logic [1:0] qCount;

   // frame engine
   eng_state_e engState;
   logic [7:0] divCnt;
   logic [63:0] frame;
   logic [6:0] bitIdx;
   logic curRead;
   logic curScan;
   logic [4:0] curPhy;
   logic [15:0] rxShift;

   // mdio input synchroniser and filter
   logic mdioS1;
   logic mdioS2;
   logic mdioS3;
   logic mdioF;

   // decode of register accesses
   wire wrCmd = regWr && (regAddr == ADDR_CMD);
   wire wrCfg = regWr && (regAddr == ADDR_CFG);
   wire wrRange = regWr && (regAddr == ADDR_SCAN_RANGE);
   wire wrCmp = regWr && (regAddr == ADDR_SCAN_CMP);
   wire rdSticky = regRd && (regAddr == ADDR_STICKY);

   // queue status
   wire qFull = (qCount == 2'(QUEUE_DEPTH));
   wire qEmpty = (qCount == 2'h0);

   // command acceptance: scan starts at once, single commands wait for queue room
   wire acceptScan = cmdValid && cmdScan && cmdOpr[1]; // [R15]
   wire acceptSingle = cmdValid && !cmdScan && !qFull; // [R10]
   wire acceptBad = cmdValid && cmdScan && !cmdOpr[1];
   wire accept = acceptScan || acceptSingle || acceptBad;

   // mdc divider: half period never shorter than the 25 MHz limit allows
   wire [7:0] halfPeriod = (divSetting < MDC_MIN_HALF) ? MDC_MIN_HALF : divSetting; // [R4]
   wire run = (engState == ENG_RUN);
   wire tick = run && (divCnt == halfPeriod - 8'h01);
   wire fallEdge = tick && mdc; // [R2]
   wire frameDone = fallEdge && (bitIdx == FRAME_BITS);

   // launch: queued single commands first, then the scan
   wire launchQ = !run && !qEmpty;
   wire launchScan = !run && qEmpty && scanOn;
   wire launch = launchQ || launchScan;
   wire [27:0] qHead = qMem[qRdPtr];
   wire [1:0] lOpr = launchQ ? qHead[1:0] : scanOpr; // [R17]
   wire [4:0] lReg = launchQ ? qHead[6:2] : scanReg;
   wire [4:0] lPhy = launchQ ? qHead[11:7] : scanPhy;
   wire [15:0] lData = launchQ ? qHead[27:12] : 16'h0000;
   wire [63:0] newFrame = {PREAMBLE, startCode, lOpr, lPhy, lReg, TA_DRIVE, lData}; // [R23] [R1]

   // returned bits: turnaround second bit then 16 data bits
   wire [16:0] rxAll = {rxShift, mdioF};
   wire rxFail = rxAll[16];
   wire [15:0] rxData = rxAll[15:0];
   wire readDone = frameDone && curRead;

   // scan compare and per-phy update masks
   wire mismatch = |((rxData ^ expectVal) & cmpMask); // [R18]
   wire scanDone = readDone && curScan;
   wire scanBad = scanDone && (mismatch || rxFail);
   wire [31:0] phyBit = 32'h0000_0001 << curPhy;
   wire [31:0] stickySet = scanBad ? phyBit : 32'h0000_0000;

   // pending flags per queue entry
   logic [QUEUE_DEPTH-1:0] entryRd;
   logic [QUEUE_DEPTH-1:0] entryWr;
   genvar gi;
   generate
      for (gi = 0; gi < QUEUE_DEPTH; gi++)
      begin : g_pend
         assign entryRd[gi] = qUsed[gi] && qMem[gi][1];
         assign entryWr[gi] = qUsed[gi] && !qMem[gi][1];
      end
   endgenerate
   wire rdPending = (|entryRd) || (run && curRead && !curScan); // [R8]
   wire wrPending = (|entryWr) || (run && !curRead); // [R8]
   wire active = cmdValid || !qEmpty || run || scanOn; // [R24]

   // read-back selection
   wire [31:0] statusWord = {27'h0, scanOn, qFull, wrPending, rdPending, active};
   wire [31:0] cmdWord = {1'b0, cmdWdata, cmdPhy, cmdReg, cmdOpr, cmdOnePass, cmdScan, cmdValid};
   wire [31:0] dataWord = {15'h0, readFail, readValue};
   wire [31:0] cfgWord = {22'h0, startCode, divSetting};
   wire [31:0] rangeWord = {19'h0, scanHi, 3'h0, scanLo};
   wire [31:0] cmpWord = {cmpMask, expectVal};
   logic [31:0] readMux;
   always_comb
   begin
      case (regAddr)
         ADDR_STATUS: readMux = statusWord;
         ADDR_CMD: readMux = cmdWord;
         ADDR_DATA: readMux = dataWord;
         ADDR_CFG: readMux = cfgWord;
         ADDR_SCAN_RANGE: readMux = rangeWord;
         ADDR_SCAN_CMP: readMux = cmpWord;
         ADDR_LAST_RESULT: readMux = lastResult;
         ADDR_LAST_VALID: readMux = lastValid;
         ADDR_STICKY: readMux = sticky;
         default: readMux = 32'h0000_0000;
      endcase
   end

   // sticky register: a new mismatch wins over the clearing read
   wire [31:0] next_sticky = (rdSticky ? ALL_ONES : sticky) & ~stickySet; // [R21]

   // interrupt while any sticky bit reports a mismatch
   assign irq = ~&sticky; // [R22]

   // bus read data, one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!nrst)
         regRdata <= 32'h0000_0000;
      else if (regRd)
         regRdata <= readMux;
      else
         regRdata <= 32'h0000_0000;
   end

   // configuration registers
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         divSetting <= CFG_DIV_RST;
         startCode <= ST_CLAUSE22; // [R12]
         scanLo <= 5'h00;
         scanHi <= 5'h00;
         expectVal <= 16'h0000;
         cmpMask <= 16'h0000;
      end
      else
      begin
         if (wrCfg)
         begin
            divSetting <= regWdata[CFG_DIV_POS +: 8];
            startCode <= regWdata[CFG_ST_POS +: 2]; // [R12]
         end
         if (wrRange)
         begin
            scanLo <= regWdata[SCAN_LO_POS +: 5];
            scanHi <= regWdata[SCAN_HI_POS +: 5];
         end
         if (wrCmp)
         begin
            expectVal <= regWdata[CMP_EXP_POS +: 16];
            cmpMask <= regWdata[CMP_MASK_POS +: 16];
         end
      end
   end

   // command register; valid drops once the command is taken
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cmdValid <= 1'b0;
         cmdScan <= 1'b0;
         cmdOnePass <= 1'b0;
         cmdOpr <= 2'h0;
         cmdReg <= 5'h00;
         cmdPhy <= 5'h00;
         cmdWdata <= 16'h0000;
      end
      else if (wrCmd && !cmdValid)
      begin
         cmdValid <= regWdata[CMD_VALID_POS]; // [R5]
         cmdScan <= regWdata[CMD_SCAN_POS]; // [R7]
         cmdOnePass <= regWdata[CMD_ONEPASS_POS];
         cmdOpr <= regWdata[CMD_OPR_POS +: 2];
         cmdReg <= regWdata[CMD_REG_POS +: 5];
         cmdPhy <= regWdata[CMD_PHY_POS +: 5];
         cmdWdata <= regWdata[CMD_WDATA_POS +: 16];
      end
      else if (accept)
         cmdValid <= 1'b0; // [R6]
   end

   // command queue: push on acceptance, pop on launch
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         qUsed <= '0;
         qWrPtr <= 1'b0;
         qRdPtr <= 1'b0;
         qCount <= 2'h0;
      end
      else
      begin
         if (acceptSingle)
         begin
            qMem[qWrPtr] <= {cmdWdata, cmdPhy, cmdReg, cmdOpr}; // [R10]
            qUsed[qWrPtr] <= 1'b1;
            qWrPtr <= ~qWrPtr;
         end
         if (launchQ)
         begin
            qUsed[qRdPtr] <= 1'b0;
            qRdPtr <= ~qRdPtr;
         end
         qCount <= qCount + {1'b0, acceptSingle} - {1'b0, launchQ};
      end
   end

   // scan control: start, walk low to high, stop after one pass if asked
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         scanOn <= 1'b0;
         scanOnePass <= 1'b0;
         scanOpr <= 2'h0;
         scanReg <= 5'h00;
         scanPhy <= 5'h00;
      end
      else if (acceptScan)
      begin
         scanOn <= 1'b1; // [R15] [R13]
         scanOnePass <= cmdOnePass;
         scanOpr <= cmdOpr;
         scanReg <= cmdReg; // [R17]
         scanPhy <= scanLo; // [R14]
      end
      else if (cmdValid && !cmdScan)
         scanOn <= 1'b0;
      else if (scanDone)
      begin
         if (scanPhy == scanHi)
         begin
            scanPhy <= scanLo; // [R14]
            if (scanOnePass)
               scanOn <= 1'b0; // [R16]
         end
         else
            scanPhy <= scanPhy + 5'h01; // [R14]
      end
   end

   // read results and scan result registers
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         readValue <= 16'h0000;
         readFail <= 1'b0;
         lastResult <= ALL_ONES;
         lastValid <= 32'h0000_0000;
         sticky <= ALL_ONES;
      end
      else
      begin
         if (readDone)
         begin
            readValue <= rxData; // [R9] [R11]
            readFail <= rxFail; // [R9]
         end
         if (scanDone)
         begin
            lastResult[curPhy] <= !mismatch; // [R19]
            lastValid[curPhy] <= !rxFail; // [R20]
         end
         sticky <= next_sticky; // [R21] [R13]
      end
   end

   // mdio input: three stages, a change counts when the last two agree
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         mdioS1 <= 1'b1;
         mdioS2 <= 1'b1;
         mdioS3 <= 1'b1;
         mdioF <= 1'b1;
      end
      else
      begin
         mdioS1 <= mdioIn;
         mdioS2 <= mdioS1;
         mdioS3 <= mdioS2;
         if (mdioS2 == mdioS3)
            mdioF <= mdioS3;
      end
   end

   // frame engine state, mdc and bit counter
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         engState <= ENG_IDLE;
         divCnt <= 8'h00;
         mdc <= 1'b0;
         bitIdx <= 7'h00;
         curRead <= 1'b0;
         curScan <= 1'b0;
         curPhy <= 5'h00;
      end
      else if (launch)
      begin
         engState <= ENG_RUN;
         divCnt <= 8'h00;
         mdc <= 1'b0;
         bitIdx <= 7'h01;
         curRead <= lOpr[1];
         curScan <= launchScan;
         curPhy <= lPhy;
      end
      else if (run)
      begin
         divCnt <= tick ? 8'h00 : divCnt + 8'h01; // [R4]
         if (tick)
            mdc <= ~mdc;
         if (frameDone)
            engState <= ENG_IDLE;
         else if (fallEdge)
            bitIdx <= bitIdx + 7'h01;
      end
   end

   // frame shift register, mdio drive and sample at each falling mdc edge
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         frame <= 64'h0;
         mdioOut <= 1'b1;
         mdioOe <= 1'b0; // [R3]
         rxShift <= 16'h0000;
      end
      else if (launch)
      begin
         mdioOut <= newFrame[63]; // [R2]
         mdioOe <= 1'b1;
         frame <= {newFrame[62:0], 1'b1};
      end
      else if (fallEdge)
      begin
         rxShift <= rxAll[15:0]; // [R2]
         if (frameDone)
         begin
            mdioOe <= 1'b0; // [R3]
            mdioOut <= 1'b1;
         end
         else
         begin
            mdioOut <= frame[63];
            mdioOe <= !(curRead && (bitIdx >= TA_INDEX)); // [R3]
            frame <= {frame[62:0], 1'b1};
         end
      end
   end
endmodule
`default_nettype wire

// >>> sim/mdio_master_checker.sv
// port-level assertions for the management-interface master
`timescale 1ns/100ps
`default_nettype none
module mdio_master_checker
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdata,
   input wire logic mdc,
   input wire logic mdioOut,
   input wire logic mdioOe,
   input wire logic mdioIn,
   input wire logic irq
);
   import mdio_master_pkg::*;
   logic mdcQ;
   logic [6:0] riseCnt;

   // count mdc rising edges while the master drives the line
   always_ff @(posedge clk)
   begin
      mdcQ <= mdc;
      riseCnt <= (!nrst || !mdioOe) ? 7'h00 : riseCnt + {6'h00, mdc & ~mdcQ};
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   mdc_high_hold_a: assert property ($rose(mdc) |-> mdc [*5])
      else $error("mdc high phase too short");
   mdc_low_hold_a: assert property ($fell(mdc) |-> !mdc [*5])
      else $error("mdc low phase too short");
   drive_on_fall_a: assert property (mdioOe && $changed(mdioOut) |-> !mdc && ($past(mdc) || $past(mdc, 2)))
      else $error("mdio changed away from a falling mdc");
   release_on_fall_a: assert property ($fell(mdioOe) |-> !mdc)
      else $error("mdio released while mdc high");
   preamble_first_a: assert property ($rose(mdioOe) |-> mdioOut && !mdc)
      else $error("frame does not open with a one");
   frame_length_a: assert property ($fell(mdioOe) |-> riseCnt == TA_INDEX || riseCnt == FRAME_BITS)
      else $error("driven part of frame has wrong bit count");
   sticky_irq_a: assert property (regRd && regAddr == ADDR_STICKY |=> (regRdata != ALL_ONES) == $past(irq))
      else $error("irq disagrees with sticky contents");
   rdata_quiet_a: assert property (!$past(regRd) |-> regRdata == 32'h0000_0000)
      else $error("read data present without a read");

   read_frame_c: cover property ($fell(mdioOe) && riseCnt == TA_INDEX);
   write_frame_c: cover property ($fell(mdioOe) && riseCnt == FRAME_BITS);
   irq_seen_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// >>> sim/phy_bus_model.sv
// behavioural phys sharing the management bus; addresses 30 and 31 are absent
`timescale 1ns/100ps
`default_nettype none
module phy_bus_model
(
   input wire logic mdc,
   input wire logic mdioOe,
   input wire logic mdioLine,
   output logic phyOut,
   output logic phyOe,
   output logic [63:0] lastFrame
);
   int n;
   logic [15:0] value;

   // line released, pull-up wins
   initial
   begin
      phyOe = 1'b0;
      phyOut = 1'b1;
      lastFrame = 64'h0;
      n = 0;
   end

   // fresh bit count per frame
   always @(posedge mdioOe)
      n = 0;

   // sample on rising mdc, answer reads after turnaround
   always @(posedge mdc)
   begin
      lastFrame = {lastFrame[62:0], mdioLine};
      n = n + 1;
      if (n == 48 && lastFrame[13] && lastFrame[11:7] < 5'h1E)
      begin
         value = {lastFrame[11:2], 6'h15};
         phyOe = 1'b1;
         phyOut = 1'b0;
      end
      else if (n > 48 && phyOe)
         phyOut = value[64 - n];
   end

   // hand the line back after the last data bit
   always @(negedge mdc)
      if (n == 64)
         phyOe <= #2 1'b0;
endmodule
`default_nettype wire

// >>> sim/test_mdio_management_master.sv
// self-checking bench for the management-interface master
`timescale 1ns/100ps
`default_nettype none
module test_mdio_management_master;
   import mdio_master_pkg::*;
   logic clk;
   logic nrst;
   logic [7:0] regAddr;
   logic [31:0] regWdata;
   logic regWr;
   logic regRd;
   logic [31:0] regRdata;
   logic mdc, mdioOut, mdioOe, irq, phyOut, phyOe;
   logic [63:0] lastFrame;
   wire logic mdioIn;
   int error_cnt;
   int compares;
   int seed;
   logic [31:0] rdv;
   logic [4:0] ph, rg;
   logic [15:0] wd;

   // wire level: master, then phy, else pull-up
   assign mdioIn = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);

   mdio_management_master dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .mdc(mdc), .mdioOut(mdioOut),
      .mdioOe(mdioOe), .mdioIn(mdioIn), .irq(irq));
   phy_bus_model phys (.mdc(mdc), .mdioOe(mdioOe), .mdioLine(mdioIn), .phyOut(phyOut),
      .phyOe(phyOe), .lastFrame(lastFrame));

   initial
      clk = 1'b0;
   always #2 clk = ~clk;

   function automatic logic [15:0] phyVal(input logic [4:0] p, input logic [4:0] r);
      phyVal = {p, r, 6'h15};
   endfunction

   function automatic logic [63:0] frm(input logic [1:0] st, input logic [1:0] op, input logic [4:0] p,
      input logic [4:0] r, input logic [15:0] d);
      frm = {PREAMBLE, st, op, p, r, TA_DRIVE, d};
   endfunction

   function automatic logic [31:0] cmd(input logic sc, input logic one, input logic [1:0] op,
      input logic [4:0] r, input logic [4:0] p, input logic [15:0] d);
      cmd = {1'b0, d, p, r, op, one, sc, 1'b1};
   endfunction

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
   begin
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
   begin
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
   begin
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
      @(posedge clk);
   end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
   begin
      rd(a, rdv);
      chk(nm, e, rdv);
   end
   endtask

   // poll status until the chosen flag is clear
   task automatic poll(input int pos);
   begin
      for (int i = 0; i < 3000; i++)
      begin
         rd(ADDR_STATUS, rdv);
         if (rdv[pos] === 1'b0)
            return;
      end
      error_cnt++;
      $display("CHECK FAILED poll status bit %0d expected 0 seen 1", pos);
   end
   endtask

   task automatic issue(input logic [31:0] c);
   begin
      poll(STAT_QFULL_POS);
      wr(ADDR_CMD, c);
   end
   endtask

   task automatic end_of_test;
   begin
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask

   // watchdog against a hung engine
   initial
   begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      $display("watchdog expired");
      end_of_test;
   end

   // main sequence
   initial
   begin
      seed = 32'h7029E0BA;
      error_cnt = 0;
      compares = 0;
      nrst = 1'b0;
      regAddr = 8'h00;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rdc(ADDR_CFG, {22'h0, ST_CLAUSE22, CFG_DIV_RST}, "cfg reset");
      rdc(ADDR_STICKY, ALL_ONES, "sticky reset");
      rdc(ADDR_LAST_VALID, 32'h0, "valid reset");
      rdc(8'h30, 32'h0, "unmapped");
      $display("reset test done");
      wr(ADDR_CFG, {22'h0, ST_CLAUSE22, 8'h08});
      for (int k = 0; k < 3; k++)
      begin
         ph = 5'($unsigned($random(seed)) % 30);
         rg = 5'($random(seed));
         wd = 16'($random(seed));
         issue(cmd(1'b0, 1'b0, 2'h1, rg, ph, wd));
         rd(ADDR_STATUS, rdv);
         chk("write pending", 3'h5, rdv[2:0]);
         poll(STAT_ACTIVE_POS);
         chk("write frame", frm(ST_CLAUSE22, 2'h1, ph, rg, wd), lastFrame);
         issue(cmd(1'b0, 1'b0, 2'h2, rg, ph, 16'h0));
         rd(ADDR_STATUS, rdv);
         chk("read pending", 3'h3, rdv[2:0]);
         poll(STAT_ACTIVE_POS);
         rdc(ADDR_STATUS, 32'h0, "status idle");
         rdc(ADDR_DATA, {16'h0, phyVal(ph, rg)}, "read data");
      end
      issue(cmd(1'b0, 1'b0, 2'h2, 5'h03, 5'h1F, 16'h0));
      poll(STAT_ACTIVE_POS);
      rd(ADDR_DATA, rdv);
      chk("absent phy", 1'b1, rdv[DATA_FAIL_POS]);
      $display("single command test done");
      issue(cmd(1'b0, 1'b0, 2'h2, 5'h01, 5'h05, 16'h0));
      issue(cmd(1'b0, 1'b0, 2'h2, 5'h02, 5'h06, 16'h0));
      poll(STAT_ACTIVE_POS);
      rdc(ADDR_DATA, {16'h0, phyVal(5'h06, 5'h02)}, "queued read");
      $display("queue test done");
      wr(ADDR_CFG, {22'h0, ST_CLAUSE45, 8'h08});
      issue(cmd(1'b0, 1'b0, 2'h0, rg, ph, wd));
      poll(STAT_ACTIVE_POS);
      chk("address frame", frm(ST_CLAUSE45, 2'h0, ph, rg, wd), lastFrame);
      issue(cmd(1'b0, 1'b0, 2'h3, rg, ph, 16'h0));
      poll(STAT_ACTIVE_POS);
      rdc(ADDR_DATA, {16'h0, phyVal(ph, rg)}, "c45 read");
      wr(ADDR_CFG, {22'h0, ST_CLAUSE22, 8'h08});
      $display("clause 45 test done");
      wr(ADDR_SCAN_RANGE, {19'h0, 5'h04, 3'h0, 5'h02});
      wr(ADDR_SCAN_CMP, {16'hFFFE, phyVal(5'h03, rg) ^ 16'h0001});
      issue(cmd(1'b1, 1'b1, 2'h2, rg, 5'h1F, wd));
      poll(STAT_ACTIVE_POS);
      rdc(ADDR_STATUS, 32'h0, "scan stopped");
      chk("last scan phy", 5'h04, lastFrame[27:23]);
      rdc(ADDR_LAST_RESULT, 32'hFFFF_FFEB, "scan result");
      rdc(ADDR_LAST_VALID, 32'h0000_001C, "scan valid");
      chk("irq raised", 1'b1, irq);
      rdc(ADDR_STICKY, 32'hFFFF_FFEB, "sticky");
      rdc(ADDR_STICKY, ALL_ONES, "sticky cleared");
      chk("irq cleared", 1'b0, irq);
      issue(cmd(1'b1, 1'b0, 2'h2, rg, 5'h00, 16'h0));
      repeat (5000) @(posedge clk);
      rdc(ADDR_STATUS, 32'h0000_0011, "scan running");
      issue(cmd(1'b0, 1'b0, 2'h1, rg, ph, wd));
      poll(STAT_ACTIVE_POS);
      chk("stop write frame", frm(ST_CLAUSE22, 2'h1, ph, rg, wd), lastFrame);
      rdc(ADDR_STICKY, 32'hFFFF_FFEB, "sticky rescan");
      $display("scan test done");
      end_of_test;
   end
endmodule

bind mdio_management_master mdio_master_checker chk (.clk(clk), .nrst(nrst), .regAddr(regAddr),
   .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .mdc(mdc),
   .mdioOut(mdioOut), .mdioOe(mdioOe), .mdioIn(mdioIn), .irq(irq));
`default_nettype wire
